// ==== core/lhp_defines.vh ====
// Constants for the LCD host write port
`ifndef LHP_DEFINES_VH
`define LHP_DEFINES_VH
`define LHP_BYTE_W 8
`define LHP_NIB_W 4
`define LHP_BITCNT_W 3
`define LHP_LAST_BIT 3'h7
`define LHP_FIFO_DEPTH 8
`define LHP_FIFO_AW 3
`define LHP_WORD_W 9
`define LHP_DC_BIT 8
`define LHP_CMD_PSAVE_HI 4'h0
`define LHP_CMD_PSAVE_MASK 8'hF0
`define LHP_CMD_PSAVE 8'h40
`define LHP_CMD_PWR 8'h20
`define LHP_CMD_PWR_MASK 8'hF0
`define LHP_CMD_ECTL 8'h28
`define LHP_ECTL_RST 5'h00
`define LHP_PSAVE_BIT 0
`define LHP_OSC_BIT 1
`define LHP_PWR_BIT 0
`define LHP_XCK_HOLD 6'h20
`endif

// ==== core/lhp_sync.v ====
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module lhp_sync #(
   parameter W = 1
) (
   input wire mclk, // System clock
   input wire ce, // Clock enable
   input wire [W-1:0] d, // Asynchronous inputs
   output wire [W-1:0] q // Synchronised outputs
);
   reg [W-1:0] s1_r; // First stage, read only by the second stage
   reg [W-1:0] s2_r; // Second stage
   // No reset: pins settle within two cycles anyway
   always @(posedge mclk) begin
      if (ce) begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule

// ==== core/lhp_fifo.v ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module lhp_fifo #(
   parameter W = 9,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire mclk, // System clock
   input wire rst, // Synchronous reset, active high
   input wire ce, // Clock enable
   input wire [W-1:0] in_data, // Word to store
   input wire in_valid, // Word offered
   output wire in_ready, // Room available
   output reg [W-1:0] out_data, // Oldest word
   output wire out_valid, // Word available
   input wire out_ready // Consumer takes word
);
   reg [W-1:0] mem [0:DEPTH-1]; // Storage
   reg [AW-1:0] wp_r; // Write pointer
   reg [AW-1:0] rp_r; // Read pointer
   reg [AW:0] cnt_r; // Occupancy
   wire push; // Accepted write
   wire pop; // Accepted read
   assign in_ready = (cnt_r != DEPTH);
   assign out_valid = (cnt_r != 0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   // Pointers and occupancy
   always @(posedge mclk) begin
      if (rst) begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else if (ce) begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
   // Storage write
   always @(posedge mclk) begin
      if (ce & push) begin
         mem[wp_r] <= in_data;
      end
   end
   // Head word shown combinationally from storage
   always @* begin
      out_data = mem[rp_r];
   end
endmodule

// ==== core/lhp_port.v ====
// Write-only host port: parallel 4/8-bit, 68/80 strobes, serial link
`timescale 1ns/1ps
`include "lhp_defines.vh"
module lhp_port (
   input wire mclk, // System clock, 40 MHz
   input wire rst, // Synchronous reset, active high
   input wire ce, // Clock enable, freezes state when low
   input wire chip_init_n, // Device init pin, active low
   input wire chip_select_n, // Chip select pin, active low
   input wire serial_parallel_select, // High parallel, low serial
   input wire bus_style_select, // High 68-style, low 80-style
   input wire width_select, // High 8-bit, low 4-bit
   input wire data_command_select, // 0 command, 1 display data
   input wire write_strobe, // Write strobe or enable pin
   input wire [7:0] data_bus, // Parallel data pins
   input wire serial_data_in, // Serial data pin
   input wire serial_clock_in, // Serial clock pin
   input wire external_clock_in, // External clock pin
   output reg [7:0] wr_data, // Byte to core
   output reg wr_is_data, // 1 display data, 0 command
   output wire wr_valid, // Byte available to core
   input wire wr_ready, // Core takes byte
   output wire in_ready, // Buffer has room
   output reg standby_r, // Standby mode active
   output reg osc_on_r, // Oscillator enabled
   output reg power_on_r, // Power circuit enabled
   output reg [4:0] contrast_r, // Drive voltage step code
   output reg [4:0] drive_level_r, // Inverse step, 31 is largest drive
   output reg clock_ok_r, // Amplifier clock source running
   output reg overrun_r // Byte lost on full buffer
);
   // Pins synchronised together so their relative order holds
   wire [17:0] pin_s; // Synchronised pin bank
   wire init_n_s; // Synced init
   wire cs_n_s; // Synced chip select
   wire par_s; // Synced interface select
   wire m68_s; // Synced bus style
   wire w8_s; // Synced width select
   wire dc_s; // Synced data/command
   wire strb_s; // Synced strobe
   wire [7:0] db_s; // Synced data pins
   wire sdi_s; // Synced serial data
   wire sck_s; // Synced serial clock
   wire xck_s; // Synced external clock
   lhp_sync #(.W(18)) u_sync (
      .mclk(mclk),
      .ce(ce),
      .d({chip_init_n, chip_select_n, serial_parallel_select,
          bus_style_select, width_select, data_command_select,
          write_strobe, data_bus[7:4], data_bus[3:0],
          serial_data_in, serial_clock_in, external_clock_in}),
      .q(pin_s)
   );
   assign init_n_s = pin_s[17];
   assign cs_n_s = pin_s[16];
   assign par_s = pin_s[15];
   assign m68_s = pin_s[14];
   assign w8_s = pin_s[13];
   assign dc_s = pin_s[12];
   assign strb_s = pin_s[11];
   assign db_s = pin_s[10:3];
   assign sdi_s = pin_s[2];
   assign sck_s = pin_s[1];
   assign xck_s = pin_s[0];

   // Local init: system reset or device pin held low, level-sensitive
   wire init; // Combined init
   assign init = rst | ~init_n_s;

   // Edge history for strobe, serial clock and external clock
   reg strb_d_r; // Previous strobe
   reg sck_d_r; // Previous serial clock
   reg xck1_r; // External clock stage one
   reg xck2_r; // External clock stage two
   reg xck3_r; // External clock previous
   wire sel; // Chip selected
   wire strb_latch; // Parallel latch edge
   wire sck_rise; // Serial clock rising
   assign sel = ~cs_n_s;
   // 68-style latches on falling enable, 80-style on rising strobe
   assign strb_latch = m68_s ? (strb_d_r & ~strb_s)
                             : (~strb_d_r & strb_s);
   assign sck_rise = ~sck_d_r & sck_s;

   // Edge history process
   always @(posedge mclk) begin
      if (init) begin
         strb_d_r <= 1'b0;
         sck_d_r <= 1'b0;
      end else if (ce) begin
         strb_d_r <= strb_s;
         sck_d_r <= sck_s;
      end
   end

   // Parallel nibble pairing and serial shifter
   reg nib_hi_r; // High nibble already taken
   reg [3:0] nib_r; // Held high nibble
   reg [7:0] shift_r; // Serial shift register
   reg [2:0] bitcnt_r; // Serial bit counter
   reg [8:0] word_nxt; // Word to push, select in top bit
   reg push_nxt; // Push request this cycle
   // Receive process: ignores everything while deselected
   always @(posedge mclk) begin
      if (init) begin
         nib_hi_r <= 1'b0;
         nib_r <= 4'h0;
         shift_r <= 8'h00;
         bitcnt_r <= 3'h0;
      end else if (ce) begin
         if (!sel) begin
            shift_r <= 8'h00;
            bitcnt_r <= 3'h0;
            nib_hi_r <= 1'b0;
         end else if (par_s) begin
            // Leftover serial state never mixes into parallel bytes
            bitcnt_r <= 3'h0;
            if (strb_latch && !w8_s) begin
               nib_hi_r <= ~nib_hi_r;
               nib_r <= db_s[7:4];
            end
         end else begin
            nib_hi_r <= 1'b0;
            if (sck_rise) begin
               shift_r <= {shift_r[6:0], sdi_s};
               bitcnt_r <= bitcnt_r + 3'h1;
            end
         end
      end
   end

   // Word assembly feeding the buffer
   always @* begin
      word_nxt = 9'h000;
      push_nxt = 1'b0;
      if (sel && par_s && strb_latch) begin
         if (w8_s) begin
            word_nxt = {dc_s, db_s};
            push_nxt = 1'b1;
         end else if (nib_hi_r) begin
            word_nxt = {dc_s, nib_r, db_s[7:4]};
            push_nxt = 1'b1;
         end
      end else if (sel && !par_s && sck_rise &&
                   bitcnt_r == `LHP_LAST_BIT) begin
         word_nxt = {dc_s, shift_r[6:0], sdi_s};
         push_nxt = 1'b1;
      end
   end

   // Buffer between pin side and core side
   wire fifo_ready; // Buffer room
   wire fifo_valid; // Buffer head valid
   wire [8:0] fifo_head; // Buffer head word
   wire take; // Local command decode takes the word too
   lhp_fifo #(.W(`LHP_WORD_W), .DEPTH(`LHP_FIFO_DEPTH),
              .AW(`LHP_FIFO_AW)) u_fifo (
      .mclk(mclk),
      .rst(init),
      .ce(ce),
      .in_data(word_nxt),
      .in_valid(push_nxt),
      .in_ready(fifo_ready),
      .out_data(fifo_head),
      .out_valid(fifo_valid),
      .out_ready(wr_ready)
   );
   assign in_ready = fifo_ready;
   assign wr_valid = fifo_valid;
   assign take = fifo_valid & wr_ready;

   // Data output copy: head shown from flops, refreshed each cycle
   always @(posedge mclk) begin
      if (init) begin
         wr_data <= 8'h00;
         wr_is_data <= 1'b0;
      end else if (ce) begin
         wr_data <= fifo_head[7:0];
         wr_is_data <= fifo_head[`LHP_DC_BIT];
      end
   end

   // Overrun: no strobe back-pressure exists on a write-only pin bus
   always @(posedge mclk) begin
      if (init) begin
         overrun_r <= 1'b0;
      end else if (ce && push_nxt && !fifo_ready) begin
         overrun_r <= 1'b1;
      end
   end

   // Mode commands seen as they leave the buffer
   wire is_cmd; // Head is a command
   reg ectl_arm_r; // Next word taken, if display data, is contrast code
   assign is_cmd = ~fifo_head[`LHP_DC_BIT];
   always @(posedge mclk) begin
      if (init) begin
         standby_r <= 1'b0;
         osc_on_r <= 1'b0;
         power_on_r <= 1'b0;
         contrast_r <= `LHP_ECTL_RST;
         drive_level_r <= 5'h1F;
         ectl_arm_r <= 1'b0;
      end else if (ce && take) begin
         ectl_arm_r <= 1'b0;
         if (is_cmd && (fifo_head[7:0] & `LHP_CMD_PSAVE_MASK) ==
             `LHP_CMD_PSAVE) begin
            standby_r <= fifo_head[`LHP_PSAVE_BIT];
            osc_on_r <= fifo_head[`LHP_OSC_BIT];
         end else if (is_cmd && fifo_head[7:0] == `LHP_CMD_ECTL) begin
            // Exact contrast code checked first, it shares the power mask
            ectl_arm_r <= 1'b1;
         end else if (is_cmd && (fifo_head[7:0] & `LHP_CMD_PWR_MASK) ==
                      `LHP_CMD_PWR) begin
            power_on_r <= fifo_head[`LHP_PWR_BIT];
         end else if (!is_cmd && ectl_arm_r) begin
            // Code zero is largest drive, thirty-one smallest
            contrast_r <= fifo_head[4:0];
            drive_level_r <= 5'h1F - fifo_head[4:0];
         end
      end
   end

   // Clock source check for the amplifier: oscillator or toggling pin
   // Each pin edge reloads a hold count so a slow clock reads steady
   reg [5:0] xck_cnt_r; // Cycles left since last pin edge
   always @(posedge mclk) begin
      if (init) begin
         xck1_r <= 1'b1;
         xck2_r <= 1'b1;
         xck3_r <= 1'b1;
         xck_cnt_r <= 6'h00;
         clock_ok_r <= 1'b0;
      end else if (ce) begin
         xck1_r <= xck_s;
         xck2_r <= xck1_r;
         xck3_r <= xck2_r;
         if (xck2_r ^ xck3_r) begin
            xck_cnt_r <= `LHP_XCK_HOLD;
         end else if (xck_cnt_r != 6'h00) begin
            xck_cnt_r <= xck_cnt_r - 6'h01;
         end
         clock_ok_r <= osc_on_r | (xck_cnt_r != 6'h00);
      end
   end
endmodule

// ==== bench/lhp_checker.sv ====
// Assertion checker bound to the host write port
`timescale 1ns/1ps
module lhp_checker (
   input wire mclk, // Clock
   input wire rst, // Reset
   input wire ce, // Enable
   input wire chip_init_n, // Init pin
   input wire chip_select_n, // Select pin
   input wire wr_valid, // Word held
   input wire wr_ready, // Core pop
   input wire in_ready, // Room left
   input wire overrun_r, // Byte lost
   input wire standby_r, // Standby
   input wire osc_on_r, // Oscillator
   input wire power_on_r, // Power
   input wire [4:0] contrast_r, // Step code
   input wire [4:0] drive_level_r, // Drive step
   input wire clock_ok_r // Clock source
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // Held init clears the port even while deselected
   init_clear_a: assert property ((!chip_init_n && ce)[*5] |->
      !wr_valid && !overrun_r && !standby_r && drive_level_r == 5'h1F)
      else $error("init did not clear the port");
   // First edge out of reset shows idle values
   reset_idle_a: assert property ($fell(rst) && $past(ce) |->
      !osc_on_r && !power_on_r && in_ready && !wr_valid)
      else $error("reset values wrong");
   // Drive step is the mirror of the code
   drive_mirror_a: assert property (drive_level_r == 5'h1F - contrast_r)
      else $error("drive step not inverse of code");
   // A buffer of eight is never both empty and full
   room_or_word_a: assert property (in_ready || wr_valid)
      else $error("buffer both empty and full");
   // A word stays offered until the core takes it
   hold_word_a: assert property (chip_init_n[*4] ##0
      (wr_valid && !wr_ready) |=> wr_valid)
      else $error("word dropped before pop");
   // Lost-byte flag only falls on init
   lost_sticky_a: assert property (chip_init_n[*4] ##0 overrun_r
      |=> overrun_r)
      else $error("overrun flag fell");
   // Long deselect brings no new words
   deselect_quiet_a: assert property ((chip_select_n && !wr_valid)[*8]
      |=> !wr_valid)
      else $error("word while deselected");
   // Oscillator running means a clock source is present
   clock_ok_a: assert property ((osc_on_r && ce) ##1 osc_on_r
      |-> clock_ok_r)
      else $error("clock source flag low");
   pop_c: cover property (wr_valid && wr_ready);
   lost_c: cover property ($rose(overrun_r));
   standby_c: cover property ($rose(standby_r));
endmodule

bind lhp_port lhp_checker chk_i (.mclk, .rst, .ce, .chip_init_n,
   .chip_select_n, .wr_valid, .wr_ready, .in_ready, .overrun_r, .standby_r,
   .osc_on_r, .power_on_r, .contrast_r, .drive_level_r, .clock_ok_r);

// ==== bench/lhp_host.sv ====
// Host processor model driving the port's pins
`timescale 1ns/1ps
module lhp_host (
   input wire mclk, // Clock
   output reg chip_select_n, // Select
   output reg serial_parallel_select, // Mode
   output reg bus_style_select, // Style
   output reg width_select, // Width
   output reg data_command_select, // Qualifier
   output reg write_strobe, // Strobe
   output reg [7:0] data_bus, // Data
   output reg serial_data_in, // Serial data
   output reg serial_clock_in, // Serial clock
   output reg external_clock_in // Ext clock
);
   // Idle pins; ext clock tied high while the oscillator is used
   initial begin
      chip_select_n = 1'b1;
      serial_parallel_select = 1'b1;
      bus_style_select = 1'b0;
      width_select = 1'b1;
      data_command_select = 1'b0;
      write_strobe = 1'b1;
      data_bus = 8'h00;
      serial_data_in = 1'b0;
      serial_clock_in = 1'b0;
      external_clock_in = 1'b1;
   end
   // Wait whole clocks; callers enter just after an edge
   task wt(input integer n);
      repeat (n) @(posedge mclk);
   endtask
   // One strobe; phases of four clocks keep the spacing legal
   task pulse(input [7:0] v, input dc, input st);
      data_bus <= v;
      data_command_select <= dc;
      wt(4);
      write_strobe <= st;
      wt(4);
      write_strobe <= ~st;
      wt(4);
      data_bus <= ~v; // Released pins show a changed level
      wt(4);
   endtask
   // Parallel byte; the strobe rests before select falls
   task par(input st, input w8, input dc, input [7:0] b, input cs);
      serial_parallel_select <= 1'b1;
      bus_style_select <= st;
      width_select <= w8;
      write_strobe <= ~st;
      wt(4);
      chip_select_n <= cs;
      wt(4);
      if (w8) begin
         pulse(b, dc, st);
      end else begin
         pulse({b[7:4], ~b[7:4]}, dc, st);
         pulse({b[3:0], b[7:4]}, dc, st);
      end
      chip_select_n <= 1'b1;
      wt(4);
   endtask
   // Serial frame of n bits, MSB first; clock rests low outside
   task ser(input dc, input [7:0] b, input integer n);
      integer i;
      serial_parallel_select <= 1'b0;
      width_select <= 1'b1;
      bus_style_select <= 1'b0;
      write_strobe <= 1'b1;
      wt(4);
      chip_select_n <= 1'b0;
      wt(4);
      for (i = 7; i > 7 - n; i = i - 1) begin
         serial_clock_in <= 1'b0;
         serial_data_in <= b[i];
         data_command_select <= dc;
         wt(4);
         serial_clock_in <= 1'b1;
         wt(4);
      end
      serial_clock_in <= 1'b0;
      serial_data_in <= ~serial_data_in;
      wt(4);
      chip_select_n <= 1'b1;
      wt(4);
   endtask
   // External clock runs only with the oscillator off
   task ext(input integer n);
      repeat (n) begin
         external_clock_in <= ~external_clock_in;
         wt(4);
      end
      external_clock_in <= 1'b1;
   endtask
endmodule

// ==== bench/lcd_host_write_port_tb.sv ====
// Self-checking bench for the host write port
`timescale 1ns/1ps
module lcd_host_write_port_tb;
   reg mclk, rst, ce, chip_init_n, wr_ready; // Bench-driven inputs
   wire chip_select_n, serial_parallel_select, bus_style_select;
   wire width_select, data_command_select, write_strobe;
   wire serial_data_in, serial_clock_in, external_clock_in;
   wire [7:0] data_bus, wr_data; // Pin bus and delivered byte
   wire wr_is_data, wr_valid, in_ready, standby_r, osc_on_r;
   wire power_on_r, clock_ok_r, overrun_r; // Status levels
   wire [4:0] contrast_r, drive_level_r; // Drive codes
   integer num_errors, comparisons, seed, i; // Bookkeeping
   reg [31:0] r; // Random draw
   reg [7:0] q [0:8]; // Bytes sent into the full buffer
   lhp_host HOST (.mclk, .chip_select_n, .serial_parallel_select,
      .bus_style_select, .width_select, .data_command_select,
      .write_strobe, .data_bus, .serial_data_in, .serial_clock_in,
      .external_clock_in);
   lhp_port DUT (.mclk, .rst, .ce, .chip_init_n, .chip_select_n,
      .serial_parallel_select, .bus_style_select, .width_select,
      .data_command_select, .write_strobe, .data_bus, .serial_data_in,
      .serial_clock_in, .external_clock_in, .wr_data, .wr_is_data,
      .wr_valid, .wr_ready, .in_ready, .standby_r, .osc_on_r,
      .power_on_r, .contrast_r, .drive_level_r, .clock_ok_r, .overrun_r);
   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Compare and count
   task chk(input [7:0] got, input [7:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Wait for a word, check it one edge later, then pop it
   task get_word(input dc, input [7:0] v);
      integer n;
      n = 0;
      @(negedge mclk);
      while (wr_valid !== 1'b1 && n < 200) begin
         @(negedge mclk);
         n = n + 1;
      end
      @(negedge mclk);
      chk({7'h00, wr_valid}, 8'h01);
      chk({7'h00, wr_is_data}, {7'h00, dc});
      chk(wr_data, v);
      @(posedge mclk);
      wr_ready <= 1'b1;
      @(posedge mclk);
      wr_ready <= 1'b0;
   endtask
   // Command byte, popped, then let its effect settle
   task cmd(input [7:0] c);
      @(posedge mclk);
      HOST.par(1'b0, 1'b1, 1'b0, c, 1'b0);
      get_word(1'b0, c);
      HOST.wt(4);
      @(negedge mclk);
   endtask
   // Verdict and end of run
   task results;
      if (num_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Watchdog far beyond the expected thousand or so clocks
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors = num_errors + 1;
      results;
   end
   initial begin
      seed = 26;
      num_errors = 0;
      comparisons = 0;
      rst = 1'b1;
      ce = 1'b1;
      chip_init_n = 1'b1;
      wr_ready = 1'b0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      HOST.wt(4);
      // Every style, width and qualifier with a random byte
      for (i = 0; i < 8; i = i + 1) begin
         r = $random(seed);
         HOST.par(i[0], i[1], i[2], r[7:0], 1'b0);
         get_word(i[2], r[7:0]);
      end
      // A strobe while deselected is ignored
      HOST.par(1'b0, 1'b1, 1'b1, 8'hA5, 1'b1);
      @(negedge mclk);
      chk({7'h00, wr_valid}, 8'h00);
      // A cut frame is forgotten, the next whole one arrives
      for (i = 0; i < 2; i = i + 1) begin
         r = $random(seed);
         @(posedge mclk);
         HOST.ser(i[0], r[15:8], 3);
         HOST.ser(i[0], r[7:0], 8);
         get_word(i[0], r[7:0]);
      end
      // Nine bytes into eight places while the core stalls
      for (i = 0; i < 9; i = i + 1) begin
         r = $random(seed);
         q[i] = r[7:0];
         HOST.par(1'b1, 1'b1, 1'b1, r[7:0], 1'b0);
      end
      @(negedge mclk);
      chk({7'h00, in_ready}, 8'h00);
      chk({7'h00, overrun_r}, 8'h01);
      for (i = 0; i < 7; i = i + 1) begin
         get_word(1'b1, q[i]);
      end
      // Init with a word queued and the chip deselected
      chip_init_n <= 1'b0;
      HOST.wt(6);
      @(negedge mclk);
      chk({7'h00, wr_valid}, 8'h00);
      chk({7'h00, overrun_r}, 8'h00);
      chk({3'h0, drive_level_r}, 8'h1F);
      @(posedge mclk);
      chip_init_n <= 1'b1;
      HOST.wt(4);
      // Standby with oscillator, power on, then leave standby with the oscillator stopped
      cmd(8'h43);
      chk({5'h00, standby_r, osc_on_r, clock_ok_r}, 8'h07);
      cmd(8'h21);
      chk({7'h00, power_on_r}, 8'h01);
      cmd(8'h40);
      chk({5'h00, standby_r, osc_on_r, clock_ok_r}, 8'h00);
      // External clock stands in for the stopped oscillator
      @(posedge mclk);
      fork
         HOST.ext(12);
         begin
            repeat (30) @(posedge mclk);
            @(negedge mclk);
            chk({7'h00, clock_ok_r}, 8'h01);
         end
      join
      // Contrast code after its command sets the mirrored drive step
      cmd(8'h28);
      HOST.par(1'b0, 1'b1, 1'b1, 8'h05, 1'b0);
      get_word(1'b1, 8'h05);
      HOST.wt(4);
      @(negedge mclk);
      chk({3'h0, contrast_r}, 8'h05);
      chk({3'h0, drive_level_r}, 8'h1A);
      // Enable low freezes the buffer even with the core popping
      HOST.par(1'b0, 1'b1, 1'b1, 8'h5A, 1'b0);
      @(posedge mclk);
      ce <= 1'b0;
      wr_ready <= 1'b1;
      repeat (4) @(posedge mclk);
      wr_ready <= 1'b0;
      ce <= 1'b1;
      get_word(1'b1, 8'h5A);
      results;
   end
endmodule
